// ===== bench/ulsc_line_swap_tb.sv
`timescale 1ns/10ps
`default_nettype none
module ulsc_line_swap_tb
	import ulsc_pkg::*;
;
	// ----------------------------------------
	// stimulus and observed signals
	// ----------------------------------------
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	ulsc_req_t req = '0;
	logic [7:0] rdata;
	logic rvalid;
	// otp pattern differs from every written value
	logic [4:0] otp_line_swap = 5'h0a;
	ulsc_pair_t [4:0] core_pair = {5{2'b10}};
	ulsc_pair_t [4:0] pin_pair;
	logic [4:0] port_line_swap;
	int n_fail = 0;
	int total_checks = 0;

	// 100 ns period
	always #50 clk = ~clk;

	ulsc_line_swap uut (
		.clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata), .rvalid(rvalid),
		.otp_line_swap(otp_line_swap), .core_pair(core_pair), .pin_pair(pin_pair),
		.port_line_swap(port_line_swap)
	);

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	// case equality so an unknown never matches
	task chk(input logic [9:0] got, input logic [9:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// one-cycle strobe, dropped at the next falling edge
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		req = '{1'b1, 1'b0, a, d};
		@(negedge clk);
		req = '0;
	endtask
	// rvalid rises at the read edge itself: judged half a cycle later, at the next fall
	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk);
		req = '{1'b0, 1'b1, a, 8'h00};
		@(negedge clk);
		req = '0;
		chk({1'b0, rvalid, rdata}, {2'b01, exp});
	endtask
	task report_and_stop;
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_otp;
		rd(8'h0b, 8'h0a);
		chk({5'h00, port_line_swap}, 10'h00a);
		chk(pin_pair, {2'b10, 2'b01, 2'b10, 2'b01, 2'b10});
	endtask
	// override clear in the write itself, so swap bits must stay
	task t_locked;
		wr(8'h0b, 8'h1f);
		rd(8'h0b, 8'h0a);
		chk({5'h00, port_line_swap}, 10'h00a);
	endtask
	task t_reserved;
		wr(8'h0b, 8'hff);
		rd(8'h0b, 8'h9f);
	endtask
	// ports 0 and 2 swapped, the rest straight through
	task t_swap;
		wr(8'h0b, 8'h85);
		repeat (2) @(negedge clk);
		chk({5'h00, port_line_swap}, 10'h005);
		chk(pin_pair, {2'b10, 2'b10, 2'b01, 2'b10, 2'b01});
		rd(8'h0c, 8'h00);
		wr(8'h0b, 8'h00);
		rd(8'h0b, 8'h0a);
		chk({5'h00, port_line_swap}, 10'h00a);
	endtask
	// reset in mid-run drops the override back to the otp source
	task t_reset;
		wr(8'h0b, 8'h9f);
		@(negedge clk);
		rst_n = 1'b0;
		@(negedge clk);
		rst_n = 1'b1;
		rd(8'h0b, 8'h0a);
		chk({5'h00, port_line_swap}, 10'h00a);
	endtask

	initial begin
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		t_otp;
		t_locked;
		t_reserved;
		t_swap;
		t_reset;
		report_and_stop;
	end
endmodule
`default_nettype wire

// ===== inc/ulsc_pkg.sv
`default_nettype none
package ulsc_pkg;
	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] ULSC_LINE_SWAP_OFFSET = 8'h0b;
	localparam int ULSC_NUM_PORTS = 5;
	localparam int ULSC_OVERRIDE_BIT = 7;
	localparam logic [7:0] ULSC_WRITE_MASK = 8'h9f;
	localparam logic [7:0] ULSC_RESET_VALUE = 8'h00;
	localparam logic [4:0] ULSC_SWAP_RESET = 5'h00;
	// swap bits sit at the bottom of the register, one per port
	localparam int ULSC_SWAP_MSB = 4;

	// register access request from the configuration loader
	typedef struct packed {
		logic wr_en;
		logic rd_en;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ulsc_req_t;

	// one port's usb 2.0 differential pair
	typedef struct packed {
		logic dp;
		logic dm;
	} ulsc_pair_t;

	// whole state of the block
	typedef struct packed {
		logic override_en;
		logic [4:0] swap;
		logic [7:0] rdata;
		logic rvalid;
		ulsc_pair_t [4:0] pins;
		logic [4:0] swap_out;
	} ulsc_state_t;
endpackage
`default_nettype wire

// ===== rtl/ulsc_line_swap.sv
`timescale 1ns/10ps
`default_nettype none
// What this block does
// RULE1 - reserved bits 6:5 read zero, writes to them ignored
// RULE2 - five swap bits in bits 4:0, one per port index
// RULE3 - swap bit 0 keeps the pair as in the pinout
// RULE4 - swap bit 1 exchanges the positive and negative data lines
// RULE5 - swap bits are read-only unless override bit 7 is set
// RULE6 - override clear: swap bits read and act as the otp copies
// RULE7 - override set: eeprom load or smbus host writes swap bits
module ulsc_line_swap
	import ulsc_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// register access from eeprom loader or smbus slave
	input wire ulsc_req_t req,
	output logic [7:0] rdata,
	output logic rvalid,
	// one-time-programmable defaults
	input wire logic [4:0] otp_line_swap,
	// pairs at the core side and at the pins
	input wire ulsc_pair_t [4:0] core_pair,
	output ulsc_pair_t [4:0] pin_pair,
	// effective swap settings for the phys
	output logic [4:0] port_line_swap
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	ulsc_state_t state_reg;
	ulsc_state_t state_next;
	logic [4:0] eff_swap;
	logic wr_hit;
	logic rd_hit;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// swap source: otp while override clear, stored bits otherwise
	function automatic logic [4:0] pick_swap(input logic ovr, input logic [4:0] stored,
		input logic [4:0] otp);
		pick_swap = ovr ? stored : otp; // [RULE6]
	endfunction

	// only the swap register is mapped; everything else reads zero
	function automatic logic hits_swap_reg(input logic [7:0] addr);
		hits_swap_reg = (addr == ULSC_LINE_SWAP_OFFSET);
	endfunction

	// one port's lanes: straight through, or with the data lines exchanged
	function automatic ulsc_pair_t map_pair(input logic swap, input ulsc_pair_t core);
		map_pair = core; // [RULE3]
		if (swap) begin
			map_pair.dp = core.dm; // [RULE4]
			map_pair.dm = core.dp; // [RULE4]
		end
	endfunction

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	// otp is taken as a static level, so no resync is spent on it
	assign eff_swap = pick_swap(state_reg.override_en, state_reg.swap, otp_line_swap);
	assign wr_hit = req.wr_en && hits_swap_reg(req.addr);
	assign rd_hit = req.rd_en && hits_swap_reg(req.addr);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	// one copy of the whole state, filled here and registered below
	always_comb begin
		state_next = state_reg;
		state_next.rvalid = 1'b0;
		// the override bit is taken on every write to the register
		if (wr_hit) begin
			state_next.override_en = req.wdata[ULSC_OVERRIDE_BIT]; // [RULE5]
			// written alongside the override bit, so it may land in the same write
			if (req.wdata[ULSC_OVERRIDE_BIT]) begin
				state_next.swap = req.wdata[ULSC_SWAP_MSB:0]; // [RULE5] [RULE7]
			end
		end
		// a read in the same cycle as a write sees the old value
		if (req.rd_en) begin
			state_next.rvalid = 1'b1;
			// unmapped addresses read zero; bits 6:5 always zero
			if (rd_hit) begin
				state_next.rdata = {state_reg.override_en, 2'b00, eff_swap}; // [RULE1]
			end else begin
				state_next.rdata = ULSC_RESET_VALUE;
			end
		end
		// pins and swap outputs trail the effective bits by one cycle
		state_next.swap_out = eff_swap;
		for (int i = 0; i < ULSC_NUM_PORTS; i++) begin
			state_next.pins[i] = map_pair(eff_swap[i], core_pair[i]); // [RULE2]
		end
	end

	// ------------------------------------------------------------
	// register
	// ------------------------------------------------------------
	// single stage for all state, so every output leaves from a flip-flop
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// outputs straight from the state register
	assign rdata = state_reg.rdata;
	assign rvalid = state_reg.rvalid;
	assign pin_pair = state_reg.pins;
	assign port_line_swap = state_reg.swap_out;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_rsvd_zero;
		@(posedge clk) disable iff (!rst_n) rvalid |-> rdata[6:5] == 2'b00;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits nonzero"); // [RULE1]

	property p_read_swap;
		@(posedge clk) disable iff (!rst_n)
		(req.rd_en && req.addr == ULSC_LINE_SWAP_OFFSET) |=> rdata[4:0] == $past(eff_swap);
	endproperty
	a_read_swap: assert property (p_read_swap) else $error("read swap mismatch"); // [RULE2]

	property p_no_swap;
		@(posedge clk) disable iff (!rst_n) !eff_swap[0] |=> pin_pair[0] == $past(core_pair[0]);
	endproperty
	a_no_swap: assert property (p_no_swap) else $error("port0 pair altered"); // [RULE3]

	property p_swap;
		@(posedge clk) disable iff (!rst_n)
		eff_swap[0] |=> pin_pair[0].dp == $past(core_pair[0].dm)
			&& pin_pair[0].dm == $past(core_pair[0].dp);
	endproperty
	a_swap: assert property (p_swap) else $error("port0 not swapped"); // [RULE4]

	property p_ro;
		@(posedge clk) disable iff (!rst_n)
		(!req.wr_en || !req.wdata[ULSC_OVERRIDE_BIT]) |=> $stable(state_reg.swap);
	endproperty
	a_ro: assert property (p_ro) else $error("swap bits changed while read-only"); // [RULE5]

	property p_otp;
		@(posedge clk) disable iff (!rst_n) !state_reg.override_en |=> port_line_swap == $past(otp_line_swap);
	endproperty
	a_otp: assert property (p_otp) else $error("swap not from otp"); // [RULE6]

	property p_write;
		@(posedge clk) disable iff (!rst_n)
		(req.wr_en && req.addr == ULSC_LINE_SWAP_OFFSET && req.wdata[ULSC_OVERRIDE_BIT])
		|=> ##1 port_line_swap == $past(req.wdata[4:0], 2);
	endproperty
	a_write: assert property (p_write) else $error("override write not applied"); // [RULE7]

	property p_rd_pulse;
		@(posedge clk) disable iff (!rst_n) req.rd_en |=> rvalid ##1 (rvalid == $past(req.rd_en));
	endproperty
	a_rd_pulse: assert property (p_rd_pulse) else $error("rvalid timing wrong"); // [RULE2]

	// ------------------------------------------------------------
	// override, per-port and rvalid checks
	// ------------------------------------------------------------
	// every write to the register sets or clears the override
	property p_ovr_write;
		@(posedge clk) disable iff (!rst_n) wr_hit |=> state_reg.override_en == $past(req.wdata[7]);
	endproperty
	a_ovr_write: assert property (p_ovr_write) else $error("override not taken"); // [RULE5]

	// nothing but a register write moves the override
	property p_ovr_hold;
		@(posedge clk) disable iff (!rst_n) !wr_hit |=> $stable(state_reg.override_en);
	endproperty
	a_ovr_hold: assert property (p_ovr_hold) else $error("override moved"); // [RULE5]

	// the override reads back in bit 7
	property p_ovr_readback;
		@(posedge clk) disable iff (!rst_n) rd_hit |=> rdata[7] == $past(state_reg.override_en);
	endproperty
	a_ovr_readback: assert property (p_ovr_readback) else $error("override readback"); // [RULE5]

	// an override write stores its swap bits in the same write
	property p_swap_store;
		@(posedge clk) disable iff (!rst_n)
		(wr_hit && req.wdata[7]) |=> state_reg.swap == $past(req.wdata[4:0]);
	endproperty
	a_swap_store: assert property (p_swap_store) else $error("swap bits not stored"); // [RULE7]

	// port 2 exchanges its lines when its bit is set
	property p_swap_p2;
		@(posedge clk) disable iff (!rst_n)
		eff_swap[2] |=> pin_pair[2].dp == $past(core_pair[2].dm)
			&& pin_pair[2].dm == $past(core_pair[2].dp);
	endproperty
	a_swap_p2: assert property (p_swap_p2) else $error("port2 not swapped"); // [RULE4]

	// port 4 passes straight through when its bit is clear
	property p_no_swap_p4;
		@(posedge clk) disable iff (!rst_n) !eff_swap[4] |=> pin_pair[4] == $past(core_pair[4]);
	endproperty
	a_no_swap_p4: assert property (p_no_swap_p4) else $error("port4 pair altered"); // [RULE3]

	// while locked the readback shows the otp copy
	property p_otp_read;
		@(posedge clk) disable iff (!rst_n)
		(rd_hit && !state_reg.override_en) |=> rdata[4:0] == $past(otp_line_swap);
	endproperty
	a_otp_read: assert property (p_otp_read) else $error("locked readback not otp"); // [RULE6]

	// with the override set the stored bits drive the ports
	property p_ovr_act;
		@(posedge clk) disable iff (!rst_n)
		state_reg.override_en |=> port_line_swap == $past(state_reg.swap);
	endproperty
	a_ovr_act: assert property (p_ovr_act) else $error("stored swap not applied"); // [RULE7]

	// no read strobe, no valid pulse
	property p_rvalid_idle;
		@(posedge clk) disable iff (!rst_n) !req.rd_en |=> !rvalid;
	endproperty
	a_rvalid_idle: assert property (p_rvalid_idle) else $error("rvalid without read"); // [RULE2]
endmodule
`default_nettype wire
